// ---- src/umc_top.sv ----
// Mode control of an asynchronous serial port behind classic Wishbone.
// Assumes the serial core gives tx, rts, baud clock and a 16x tick.
// Functional notes
// - With port_on set the module takes its pins as pin_use_select says.
// - With port_on clear all pins go back to the port latches, core idle.
// - idle_halt stops the core during Idle, otherwise it keeps running.
// - infrared_codec_on turns on both the infrared encoder and decoder.
// - The infrared codec is only valid with high_speed_baud at zero.
// - Pin use 11 takes tx, rx and the baud clock; cts stays on latches.
// - Pin use 10 takes tx, rx, cts and rts; 01 takes tx, rx and rts.
// - Pin use 00 takes only tx and rx; cts and rts/bclk stay on latches.
// - Wake in Sleep flags an rx falling edge and self-clears on the rise.
// - loopback_select routes transmit back into receive.
// - autobaud_on measures the next sync character, then self-clears.
// - Mode bits 14 and 10 always read as zero.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module umc_top import umc_pkg::*; (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Interrupt
  output logic IRQ,
  // Device power state
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE,
  // Serial core side
  input wire logic CORE_TX,
  input wire logic CORE_RTS,
  input wire logic CORE_BCLK,
  input wire logic CORE_TICK16,
  output logic CORE_RX,
  output logic CORE_CTS,
  output logic CORE_RUN,
  output logic CORE_RTS_SIMPLEX,
  output logic [B_FMT_HI:0] CORE_FORMAT,
  output logic [AB_CNT_W-1:0] CORE_BAUD_COUNT,
  output logic CORE_BAUD_LOAD,
  // Port latch side
  input wire logic [3:0] LAT_O,
  input wire logic [3:0] LAT_OE_N,
  output logic [3:0] MODULE_OWN,
  // Pins: tx, rx, cts, rts/bclk
  input wire logic [3:0] PIN_I,
  output logic [3:0] PIN_O,
  output logic [3:0] PIN_OE_N
);

  typedef struct packed {
    logic [15:0] mode;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] ien;
    logic [AB_CNT_W-1:0] baud;
    logic baud_load;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic rx_d;
    logic wake_seen;
    logic conflict_d;
    logic tx_d;
    logic [4:0] tx_phase;
    logic [4:0] rx_hold;
    logic core_rx;
    logic core_cts;
    logic core_run;
    logic [3:0] pin_o;
    logic [3:0] pin_oe_n;
  } umc_state_t;

  localparam umc_state_t ST_RESET = '{mode: MODE_RESET, rx_d: 1'b1,
    tx_d: 1'b1, core_rx: 1'b1, pin_oe_n: PINS_RELEASED, default: '0};

  function automatic logic [3:0] own_mask(input logic on,
                                          input logic [1:0] pin_sel);
    logic [3:0] m;
    m = '0;
    if (on) begin
      m[P_TX] = 1'b1;
      m[P_RX] = 1'b1;
      case (pin_sel)
        PIN_RTS: m[P_RTS] = 1'b1;
        PIN_FLOW: begin
          m[P_CTS] = 1'b1;
          m[P_RTS] = 1'b1;
        end
        PIN_BCLK: m[P_RTS] = 1'b1;
        default: m = m;
      endcase
    end
    return m;
  endfunction

  logic rst_s1;
  logic rst_n;
  umc_state_t r;
  umc_state_t n;
  logic req;
  logic wr;
  logic rx_pin;
  logic rx_fall;
  logic rx_rise;
  logic ir_act;
  logic conflict;
  logic run;
  logic tx_enc;
  logic rx_dec;
  logic [1:0] pin_sel;
  logic [3:0] own;
  logic [3:0] mod_o;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  umc_ab_if ab();

  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  assign req = WB_CYC_I & WB_STB_I & ~r.ack;
  assign wr = req & WB_WE_I;
  assign rx_pin = PIN_I[P_RX] ^ r.mode[B_RXINV];
  assign rx_fall = r.rx_d & ~rx_pin;
  assign rx_rise = ~r.rx_d & rx_pin;
  assign pin_sel = r.mode[B_PIN_HI:B_PIN_LO];
  // codec held off while high-speed baud is selected
  assign conflict = r.mode[B_IR] & r.mode[B_HSB];
  assign ir_act = r.mode[B_IR] & ~r.mode[B_HSB];
  assign run = r.mode[B_PORT_ON] & ~(r.mode[B_IDLE_HALT] & IDLE_MODE);
  assign own = own_mask(r.mode[B_PORT_ON], pin_sel);
  // short pulse for each zero bit
  assign tx_enc = ~r.tx_d & (r.tx_phase < IR_PULSE);
  assign rx_dec = ir_act ? (r.rx_hold == 5'h00) : rx_pin;

  always_comb begin
    mod_o = MOD_OE_N;
    // tx line idles while looped back
    mod_o[P_TX] = r.mode[B_LOOP] ? 1'b1 : (ir_act ? tx_enc : CORE_TX);
    // shared pin carries baud clock for code 11
    mod_o[P_RTS] = (pin_sel == PIN_BCLK) ? CORE_BCLK : CORE_RTS;
  end

  assign ab.rx = rx_pin;
  // measurement armed by the mode bit
  assign ab.arm = r.mode[B_AUTOBAUD_ON] & run;

  umc_autobaud u_ab (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .bus(ab)
  );

  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    n.ack = req;
    n.baud_load = 1'b0;
    n.rx_d = rx_pin;
    // wake edge detect and hardware clear
    if (!r.mode[B_WAKE]) begin
      n.wake_seen = 1'b0;
    end
    if (r.mode[B_WAKE] & SLEEP_MODE & rx_fall) begin
      ev[EV_WAKE] = 1'b1;
      n.wake_seen = 1'b1;
    end
    if (r.wake_seen & rx_rise) begin
      n.mode[B_WAKE] = 1'b0;
      n.wake_seen = 1'b0;
    end
    if (ab.done) begin
      n.mode[B_AUTOBAUD_ON] = 1'b0;
      n.baud = ab.count;
      n.baud_load = 1'b1;
      ev[EV_AUTOBAUD_ON] = 1'b1;
    end
    n.conflict_d = conflict;
    if (conflict & ~r.conflict_d) begin
      ev[EV_IRC] = 1'b1;
    end
    if (wr) begin
      case (WB_ADR_I)
        OFF_MODE: begin
          if (WB_SEL_I[0]) begin
            n.mode[7:0] = WB_DAT_I[7:0];
          end
          if (WB_SEL_I[1]) begin
            n.mode[15:8] = WB_DAT_I[15:8];
          end
        end
        OFF_IEN: begin
          if (WB_SEL_I[0]) begin
            n.ien = WB_DAT_I[EV_W-1:0];
          end
        end
        OFF_CLR: begin
          if (WB_SEL_I[0]) begin
            clr = WB_DAT_I[EV_W-1:0];
          end
        end
        default: n.ien = n.ien;
      endcase
    end
    n.mode = n.mode & MODE_WMASK;
    // New events win over a clear
    n.stat = (r.stat & ~clr) | ev;
    n.irq = |(n.stat & n.ien);
    n.rdat = '0;
    if (req & ~WB_WE_I) begin
      case (WB_ADR_I)
        OFF_MODE: n.rdat[15:0] = r.mode & MODE_WMASK;
        OFF_STAT: n.rdat[EV_W-1:0] = r.stat;
        OFF_IEN: n.rdat[EV_W-1:0] = r.ien;
        OFF_BAUD: n.rdat[AB_CNT_W-1:0] = r.baud;
        default: n.rdat = '0;
      endcase
    end
    // counters held at zero while the port is off
    if (!r.mode[B_PORT_ON]) begin
      n.tx_phase = '0;
      n.rx_hold = '0;
      n.tx_d = 1'b1;
    end else begin
      n.tx_d = CORE_TX;
      if (CORE_TX != r.tx_d) begin
        n.tx_phase = '0;
      end else if (CORE_TICK16) begin
        n.tx_phase = (r.tx_phase == IR_LAST) ? 5'h00 : r.tx_phase + 5'h01;
      end
      // decoder stretches each pulse to one bit
      if (ir_act & rx_pin) begin
        n.rx_hold = IR_TICKS;
      end else if (CORE_TICK16 && r.rx_hold != 5'h00) begin
        n.rx_hold = r.rx_hold - 5'h01;
      end
    end
    n.core_run = run;
    if (!r.mode[B_PORT_ON]) begin
      n.core_rx = 1'b1;
    end else if (r.mode[B_LOOP]) begin
      n.core_rx = CORE_TX;
    end else begin
      n.core_rx = rx_dec;
    end
    n.core_cts = own[P_CTS] ? (r.mode[B_LOOP] ? CORE_RTS : PIN_I[P_CTS])
                            : 1'b0;
    n.pin_o = (own & mod_o) | (~own & LAT_O);
    n.pin_oe_n = (own & MOD_OE_N) | (~own & LAT_OE_N);
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  assign WB_DAT_O = r.rdat;
  assign WB_ACK_O = r.ack;
  assign IRQ = r.irq;
  assign CORE_RX = r.core_rx;
  assign CORE_CTS = r.core_cts;
  assign CORE_RUN = r.core_run;
  // rts style straight from the mode register
  assign CORE_RTS_SIMPLEX = r.mode[B_RTS_STYLE];
  assign CORE_FORMAT = r.mode[B_FMT_HI:0];
  assign CORE_BAUD_COUNT = r.baud;
  assign CORE_BAUD_LOAD = r.baud_load;
  assign MODULE_OWN = own;
  assign PIN_O = r.pin_o;
  assign PIN_OE_N = r.pin_oe_n;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  property p_port_on;
    r.mode[B_PORT_ON] |=> !PIN_OE_N[P_TX] && PIN_OE_N[P_RX];
  endproperty
  a_port_on: assert property (p_port_on)
    else $error("owned tx not driven or rx not released");

  property p_port_off;
    !r.mode[B_PORT_ON] |=> PIN_O == $past(LAT_O)
      && PIN_OE_N == $past(LAT_OE_N) && !CORE_RUN;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("pins not returned to latches when off");

  property p_idle;
    r.mode[B_PORT_ON] |=> CORE_RUN
      == !$past(r.mode[B_IDLE_HALT] && IDLE_MODE);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle halt gating wrong");

  property p_ir_tx;
    ir_act && r.tx_d && r.mode[B_PORT_ON] && !r.mode[B_LOOP]
      |=> PIN_O[P_TX] == 1'b0;
  endproperty
  a_ir_tx: assert property (p_ir_tx)
    else $error("encoder pulsed on a one bit");

  property p_ir_off;
    !r.mode[B_IR] && r.mode[B_PORT_ON] && !r.mode[B_LOOP]
      |=> PIN_O[P_TX] == $past(CORE_TX);
  endproperty
  a_ir_off: assert property (p_ir_off)
    else $error("tx not passed through with codec off");

  property p_hsb;
    conflict && !r.conflict_d && r.mode[B_PORT_ON] && !r.mode[B_LOOP]
      |=> CORE_RX == $past(rx_pin) && r.stat[EV_IRC];
  endproperty
  a_hsb: assert property (p_hsb)
    else $error("codec active with high speed baud");

  property p_bclk;
    r.mode[B_PORT_ON] && pin_sel == PIN_BCLK |=> PIN_O[P_RTS]
      == $past(CORE_BCLK) && PIN_O[P_CTS] == $past(LAT_O[P_CTS]);
  endproperty
  a_bclk: assert property (p_bclk)
    else $error("baud clock pin use wrong");

  property p_flow;
    r.mode[B_PORT_ON] && pin_sel == PIN_FLOW
      |=> PIN_OE_N[P_CTS] && !PIN_OE_N[P_RTS];
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow pins not taken");

  property p_txrx;
    r.mode[B_PORT_ON] && pin_sel == PIN_TXRX |=> PIN_O[P_RTS]
      == $past(LAT_O[P_RTS]) && PIN_OE_N[P_CTS] == $past(LAT_OE_N[P_CTS]);
  endproperty
  a_txrx: assert property (p_txrx)
    else $error("latch pins taken in tx rx mode");

  property p_wake;
    r.mode[B_WAKE] && SLEEP_MODE && rx_fall
      |=> r.stat[EV_WAKE] && r.wake_seen;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake edge not flagged");

  property p_wake_clr;
    r.wake_seen && rx_rise && !wr |=> !r.mode[B_WAKE];
  endproperty
  a_wake_clr: assert property (p_wake_clr)
    else $error("wake bit not cleared on rise");

  property p_loop;
    r.mode[B_PORT_ON] && r.mode[B_LOOP]
      |=> CORE_RX == $past(CORE_TX) && PIN_O[P_TX];
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback path wrong");

  property p_autobaud_on;
    ab.done && !wr |=> !r.mode[B_AUTOBAUD_ON] && CORE_BAUD_LOAD
      && CORE_BAUD_COUNT == $past(ab.count);
  endproperty
  a_autobaud_on: assert property (p_autobaud_on)
    else $error("autobaud completion not handled");

  property p_rsvd;
    WB_ACK_O && !WB_WE_I && WB_ADR_I == OFF_MODE
      |-> !WB_DAT_O[B_RSV14] && !WB_DAT_O[B_RSV10];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unimplemented mode bit read as one");

  property p_reset;
    $rose(rst_n) |-> r.mode == MODE_RESET && !CORE_RUN;
  endproperty
  a_reset: assert property (p_reset)
    else $error("mode not clear after reset");

endmodule

// ---- src/umc_pkg.sv ----
// Shared constants and types for the serial port mode-control block.
// Assumes a 32-bit classic Wishbone master and a 16x baud tick from the core.
package umc_pkg;

  // Register byte offsets
  localparam int ADR_W = 8;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CLR = 8'h08;
  localparam logic [7:0] OFF_IEN = 8'h0C;
  localparam logic [7:0] OFF_BAUD = 8'h10;

  // Mode register layout
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hBBFF;
  localparam int B_PORT_ON = 15;
  localparam int B_RSV14 = 14;
  localparam int B_IDLE_HALT = 13;
  localparam int B_IR = 12;
  localparam int B_RTS_STYLE = 11;
  localparam int B_RSV10 = 10;
  localparam int B_PIN_HI = 9;
  localparam int B_PIN_LO = 8;
  localparam int B_WAKE = 7;
  localparam int B_LOOP = 6;
  localparam int B_AUTOBAUD_ON = 5;
  localparam int B_RXINV = 4;
  localparam int B_HSB = 3;
  localparam int B_FMT_HI = 3;

  // Pin-use select codes
  localparam logic [1:0] PIN_TXRX = 2'h0;
  localparam logic [1:0] PIN_RTS = 2'h1;
  localparam logic [1:0] PIN_FLOW = 2'h2;
  localparam logic [1:0] PIN_BCLK = 2'h3;

  // Pin vector indices and enables when the module owns a pin
  localparam int P_TX = 0;
  localparam int P_RX = 1;
  localparam int P_CTS = 2;
  localparam int P_RTS = 3;
  localparam logic [3:0] MOD_OE_N = 4'h6;
  localparam logic [3:0] PINS_RELEASED = 4'hF;

  // Interrupt events
  localparam int EV_W = 3;
  localparam int EV_WAKE = 0;
  localparam int EV_AUTOBAUD_ON = 1;
  localparam int EV_IRC = 2;

  // Infrared pulse timing in 16x ticks
  localparam logic [4:0] IR_TICKS = 5'h10;
  localparam logic [4:0] IR_LAST = 5'h0F;
  localparam logic [4:0] IR_PULSE = 5'h03;

  // Baud measurement
  localparam int AB_CNT_W = 16;
  localparam logic [2:0] AB_EDGES = 3'h4;
  localparam logic [AB_CNT_W-1:0] AB_CNT_MAX = 16'hFFFF;
  localparam logic [AB_CNT_W-1:0] AB_CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    AB_IDLE = 3'b001,
    AB_WAIT = 3'b010,
    AB_COUNT = 3'b100
  } umc_ab_state_t;

endpackage

// ---- src/umc_ab_if.sv ----
// Link between the mode-control top and its baud measurement unit.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface umc_ab_if;
  import umc_pkg::*;
  logic rx;
  logic arm;
  logic done;
  logic [AB_CNT_W-1:0] count;
  modport ctl(output rx, output arm, input done, input count);
  modport meas(input rx, input arm, output done, output count);
endinterface

// ---- src/umc_autobaud.sv ----
// Baud measurement on a sync character received after arming.
// Assumes rx is synchronous and idles high; arm stays high until done.
`timescale 1ns/1ps
module umc_autobaud import umc_pkg::*; (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Control link
  umc_ab_if.meas bus
);

  typedef struct packed {
    umc_ab_state_t st;
    logic rx_d;
    logic [2:0] edges;
    logic [AB_CNT_W-1:0] cnt;
    logic [AB_CNT_W-1:0] result;
    logic done;
  } umc_ab_reg_t;

  localparam umc_ab_reg_t AB_RESET = '{st: AB_IDLE, rx_d: 1'b1,
                                       default: '0};

  umc_ab_reg_t r_reg;
  umc_ab_reg_t r_next;
  logic fall;

  assign fall = r_reg.rx_d & ~bus.rx;
  assign bus.done = r_reg.done;
  assign bus.count = r_reg.result;

  always_comb begin
    r_next = r_reg;
    r_next.rx_d = bus.rx;
    r_next.done = 1'b0;
    case (r_reg.st)
      AB_IDLE: begin
        if (bus.arm) begin
          r_next.st = AB_WAIT;
        end
      end
      AB_WAIT: begin
        if (!bus.arm) begin
          r_next.st = AB_IDLE;
        end else if (fall) begin
          // Start bit opens the window
          r_next.st = AB_COUNT;
          r_next.cnt = AB_CNT_ONE;
          r_next.edges = '0;
        end
      end
      AB_COUNT: begin
        if (r_reg.cnt != AB_CNT_MAX) begin
          r_next.cnt = r_reg.cnt + AB_CNT_ONE;
        end
        if (!bus.arm) begin
          r_next.st = AB_IDLE;
        end else if (fall) begin
          r_next.edges = r_reg.edges + 3'h1;
          // Fourth data falling edge closes eight bit times
          if (r_reg.edges == AB_EDGES - 3'h1) begin
            r_next.result = r_reg.cnt;
            r_next.done = 1'b1;
            r_next.st = AB_IDLE;
          end
        end
      end
      default: r_next = AB_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= AB_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// ---- dv/umc_remote.sv ----
// Remote serial transceiver model facing the port pins.
// Assumes the bench resolves pin levels and shares the system clock.
`timescale 1ns/1ps
module umc_remote (
  // Clock
  input wire logic clk,
  // Line levels
  input wire logic tx_lvl,
  output logic rx_drv,
  output logic cts_n_drv
);
  initial begin
    rx_drv = 1'b1;
    cts_n_drv = 1'b0;
  end

  task automatic set_rx(input logic v);
    @(posedge clk);
    rx_drv <= v;
  endtask

  // Start low, lsb first, stop high
  task automatic send_byte(input logic [7:0] b, input int bit_cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      set_rx(f[i]);
      repeat (bit_cyc - 1) @(posedge clk);
    end
  endtask

  task automatic send_sync_then(input logic [7:0] d, input int bit_cyc);
    send_byte(8'h55, bit_cyc);
    send_byte(d, bit_cyc);
  endtask
endmodule

// ---- dv/test_uart_mode_control.sv ----
// Self-checking bench for the serial port mode-control block.
// Assumes the remote transceiver model and a 10 MHz system clock.
`timescale 1ns/1ps
module test_uart_mode_control import umc_pkg::*; ;
  typedef struct packed {
    logic [15:0] wr;
    logic [3:0] own;
  } umc_row_t;
  localparam logic [3:0] LAT_V = 4'hA;
  localparam logic [3:0] LAT_OEN = 4'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic tx = 1'b1;
  logic rts = 1'b0;
  logic tick = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic ack, irq, c_rx, c_cts, c_run, c_simp, bload, rem_rx, rem_cts;
  logic [3:0] fmt, own, pin_o, oe_n, pin_i;
  logic [15:0] bcnt;
  int n_fail = 0;
  int n_tests = 0;
  umc_row_t rows [7] = '{'{16'h0000, 4'h0}, '{16'h8000, 4'h3},
    '{16'h8100, 4'hB}, '{16'h8200, 4'hF}, '{16'hC700, 4'hB},
    '{16'h0300, 4'h0}, '{16'h880B, 4'h3}};

  always #50 clk = ~clk;
  always @(posedge clk) tick <= ~tick;

  // Wire level from every driver, pull-up when nobody drives
  always_comb begin
    pin_i[0] = oe_n[0] ? 1'b1 : pin_o[0];
    pin_i[1] = oe_n[1] ? rem_rx : pin_o[1];
    pin_i[2] = oe_n[2] ? rem_cts : pin_o[2];
    pin_i[3] = oe_n[3] ? 1'b1 : pin_o[3];
  end

  umc_top u_umc_top (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .IRQ(irq),
    .IDLE_MODE(idle), .SLEEP_MODE(sleep), .CORE_TX(tx), .CORE_RTS(rts),
    .CORE_BCLK(1'b1), .CORE_TICK16(tick), .CORE_RX(c_rx),
    .CORE_CTS(c_cts), .CORE_RUN(c_run), .CORE_RTS_SIMPLEX(c_simp),
    .CORE_FORMAT(fmt), .CORE_BAUD_COUNT(bcnt), .CORE_BAUD_LOAD(bload),
    .LAT_O(LAT_V), .LAT_OE_N(LAT_OEN), .MODULE_OWN(own), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE_N(oe_n));

  umc_remote u_umc_remote (.clk(clk), .tx_lvl(pin_i[0]),
    .rx_drv(rem_rx), .cts_n_drv(rem_cts));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dw <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dr;
    if (ack !== 1'b1) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  initial begin
    logic [31:0] q;
    logic [3:0] e_oe;
    int n;
    int ones;
    settle(5);
    chk({irq, ack, c_run, c_rx, oe_n, own}, 12'h1F0);
    @(posedge clk) rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(OFF_MODE, 32'h0);
    foreach (rows[i]) begin
      wr(OFF_MODE, {16'h0, rows[i].wr});
      rd_chk(OFF_MODE, {16'h0, rows[i].wr & 16'hBBFF});
      settle(2);
      e_oe = (MOD_OE_N & rows[i].own) | (LAT_OEN & ~rows[i].own);
      chk(own, rows[i].own);
      chk({oe_n, pin_o[3], pin_o[0]}, {e_oe,
        rows[i].own[3] ? &rows[i].wr[9:8] : LAT_V[3],
        rows[i].own[0] ? 1'b1 : LAT_V[0]});
      chk({c_run, c_simp, fmt},
        {rows[i].wr[15], rows[i].wr[11], rows[i].wr[3:0]});
    end
    // Stop in idle
    @(posedge clk) idle <= 1'b1;
    wr(OFF_MODE, 32'hA000);
    settle(2);
    chk(c_run, 1'b0);
    wr(OFF_MODE, 32'h8000);
    settle(2);
    chk(c_run, 1'b1);
    @(posedge clk) idle <= 1'b0;
    // Loopback both ways
    wr(OFF_MODE, 32'h8240);
    tx <= 1'b0;
    rts <= 1'b1;
    settle(2);
    chk({c_rx, c_cts, pin_o[0]}, 3'b011);
    @(posedge clk) tx <= 1'b1;
    settle(2);
    chk(c_rx, 1'b1);
    // Encoder pulses on a held zero
    wr(OFF_MODE, 32'h9000);
    tx <= 1'b0;
    ones = 0;
    repeat (64) begin
      @(posedge clk);
      if (pin_o[0] === 1'b1) ones++;
    end
    chk(ones >= 8 && ones <= 16, 1'b1);
    tx <= 1'b1;
    // Codec with fast baud flagged, masked, cleared
    wr(OFF_IEN, 32'h4);
    wr(OFF_MODE, 32'h9008);
    settle(4);
    chk(irq, 1'b1);
    rd_chk(OFF_STAT, 32'h4);
    wr(OFF_IEN, 32'h0);
    settle(3);
    chk(irq, 1'b0);
    wr(OFF_IEN, 32'h4);
    wr(OFF_CLR, 32'h4);
    settle(3);
    chk(irq, 1'b0);
    rd_chk(OFF_CLR, 32'h0);
    wr(8'h20, 32'hFFFF);
    rd_chk(8'h20, 32'h0);
    wr(OFF_STAT, 32'h7);
    rd_chk(OFF_STAT, 32'h0);
    // Wake on start edge in sleep
    wr(OFF_MODE, 32'h8080);
    wr(OFF_IEN, 32'h1);
    sleep <= 1'b1;
    u_umc_remote.set_rx(1'b0);
    settle(6);
    chk(irq, 1'b1);
    rd_chk(OFF_MODE, 32'h8080);
    u_umc_remote.set_rx(1'b1);
    settle(4);
    rd_chk(OFF_MODE, 32'h8000);
    rd_chk(OFF_STAT, 32'h1);
    wr(OFF_CLR, 32'h1);
    sleep <= 1'b0;
    // Baud measurement on the sync char
    wr(OFF_MODE, 32'h8020);
    settle(2);
    n = 0;
    fork
      u_umc_remote.send_sync_then(8'hA3, 8);
      while (bload !== 1'b1 && n < 300) begin
        @(posedge clk);
        n++;
      end
    join
    chk(n < 300, 1'b1);
    rd_chk(OFF_MODE, 32'h8000);
    rd_chk(OFF_STAT, 32'h2);
    wb(1'b0, OFF_BAUD, 32'h0, q);
    chk(q, 32'h40);
    chk({16'h0, bcnt}, 32'h40);
    chk(q >= 63 && q <= 66, 1'b1);
    finish_test;
  end
endmodule
